// [logic/common_command_status_unit.sv]
// Common command interpreter with standard event status and reply output queue.
`timescale 1ns/1ps
`default_nettype none
module common_command_status_unit
  import ccsu_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Parsed commands
  input wire logic i_cmd_valid,
  input wire cmd_t i_cmd_code,
  input wire logic i_cmd_query,
  input wire logic [7:0] i_cmd_arg,
  input wire logic i_cmd_after_term,
  output logic o_cmd_ready,
  // Output queue
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  input wire logic i_rsp_ready,
  // Device events and completion
  input wire logic i_evt_cmd_err,
  input wire logic i_evt_exe_err,
  input wire logic i_evt_dev_err,
  input wire logic i_evt_qry_err,
  input wire logic i_prev_done,
  input wire logic i_level_settled,
  input wire logic i_trig_pending,
  input wire logic i_oper_summary,
  input wire logic i_ques_summary,
  // Status and clearing
  output logic [7:0] o_status_byte,
  output logic o_clear_events,
  output logic o_clear_errq,
  // Nonvolatile storage
  input wire logic i_nv_psc,
  input wire logic [7:0] i_nv_ese,
  input wire logic [7:0] i_nv_sre,
  output logic o_nv_wr,
  output logic [7:0] o_nv_ese,
  output logic [7:0] o_nv_sre,
  output logic o_nv_psc,
  // Commands handled elsewhere
  output logic o_fwd_valid,
  output cmd_t o_fwd_code,
  output logic [7:0] o_fwd_arg
);

  // Query-only commands refuse the setting form; setting-only ones refuse the query.
  function automatic logic legal_form(input cmd_t code, input logic q);
    logic ok;
    ok = 1'b0;
    unique case (code)
      CMD_ESR, CMD_IDN, CMD_STB, CMD_TST: ok = q;
      CMD_CLS, CMD_RST, CMD_WAI, CMD_RCL, CMD_SAV, CMD_TRG: ok = ~q;
      CMD_ESE, CMD_SRE, CMD_PSC, CMD_OPC: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Picks one reply character; the last one is always the line terminator.
  function automatic logic [7:0] rsp_char(input logic idn, input logic [5:0] idx,
                                          input logic [5:0] len, input logic [23:0] num);
    logic [7:0] c;
    c = CHAR_NL;
    if (idx != len - 6'h01) begin
      if (idn) begin
        c = IDN_STR[8*(IDN_LEN-1-int'(idx)) +: 8];
      end else begin
        c = num[8*(2-int'(idx[1:0])) +: 8];
      end
    end
    return c;
  endfunction

  state_t state_ff, nxt_state;
  logic init_ff;
  logic psc_ff;
  logic [7:0] ese_ff, sre_ff, esr_ff;
  logic opc_pend_ff;
  logic rsp_idn_ff;
  logic [5:0] rsp_idx_ff, rsp_len_ff;
  logic [23:0] rsp_num_ff;

  logic take, legal, run, bad, clash, do_cls, flush, ops_done, opc_fire, esr_read;
  logic set_cmd, is_q;
  logic [7:0] esr_set, stb_now, num_val;
  logic load, load_idn;
  logic [5:0] new_len;
  logic [23:0] new_num;
  logic [7:0] hund, tens, ones;
  logic hs, last;

  assign take = i_cmd_valid & o_cmd_ready;
  assign legal = legal_form(i_cmd_code, i_cmd_query);
  assign bad = take & ~legal;
  // A new query while a reply is still queued is a query error and is dropped.
  assign clash = take & legal & i_cmd_query & (state_ff == ST_REPLY);
  assign run = take & legal & ~clash;
  assign set_cmd = run & ~i_cmd_query;
  assign is_q = run & i_cmd_query;
  assign do_cls = set_cmd & (i_cmd_code == CMD_CLS);
  assign flush = do_cls & i_cmd_after_term;
  assign ops_done = i_prev_done & i_level_settled & ~i_trig_pending;
  assign opc_fire = opc_pend_ff & (ops_done | do_cls);
  assign esr_read = is_q & (i_cmd_code == CMD_ESR);
  assign hs = o_rsp_valid & i_rsp_ready;
  assign last = rsp_idx_ff == rsp_len_ff;

  always_comb begin
    stb_now = STB_RESET;
    stb_now[STB_OPER] = i_oper_summary;
    stb_now[STB_ESB] = |(esr_ff & ese_ff);
    stb_now[STB_MAV] = o_rsp_valid;
    stb_now[STB_QUES] = i_ques_summary;
    stb_now[STB_MSS] = |(stb_now & sre_ff);
  end

  always_comb begin
    esr_set = 8'h00;
    esr_set[ESR_CME] = i_evt_cmd_err | bad;
    esr_set[ESR_EXE] = i_evt_exe_err |
                       (set_cmd & (i_cmd_code == CMD_RCL || i_cmd_code == CMD_SAV) &
                        (i_cmd_arg > SLOT_MAX));
    esr_set[ESR_DDE] = i_evt_dev_err;
    esr_set[ESR_QYE] = i_evt_qry_err | clash;
    esr_set[ESR_OPC] = opc_fire;
  end

  // Reply source selection for numeric and identification replies.
  always_comb begin
    load = 1'b0;
    load_idn = 1'b0;
    num_val = 8'h00;
    if (state_ff == ST_OPCQ && ops_done) begin
      load = 1'b1;
      num_val = 8'h01;
    end else if (is_q && state_ff == ST_IDLE) begin
      load = i_cmd_code != CMD_OPC;
      unique case (i_cmd_code)
        CMD_ESE: num_val = ese_ff;
        CMD_ESR: num_val = esr_ff;
        CMD_SRE: num_val = sre_ff;
        CMD_STB: num_val = stb_now;
        CMD_PSC: num_val = {7'h00, psc_ff};
        CMD_IDN: load_idn = 1'b1;
        default: num_val = 8'h00;
      endcase
    end
    hund = num_val / 8'h64;
    tens = (num_val / 8'h0A) % 8'h0A;
    ones = num_val % 8'h0A;
    if (num_val >= 8'h64) begin
      new_num = {CHAR_ZERO + hund, CHAR_ZERO + tens, CHAR_ZERO + ones};
      new_len = 6'h04;
    end else if (num_val >= 8'h0A) begin
      new_num = {CHAR_ZERO + tens, CHAR_ZERO + ones, 8'h00};
      new_len = 6'h03;
    end else begin
      new_num = {CHAR_ZERO + ones, 16'h0000};
      new_len = 6'h02;
    end
    if (load_idn) begin
      new_len = IDN_REPLY_LEN;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (load) begin
          nxt_state = ST_REPLY;
        end else if (is_q && i_cmd_code == CMD_OPC) begin
          nxt_state = ST_OPCQ;
        end else if (set_cmd && i_cmd_code == CMD_WAI) begin
          nxt_state = ST_WAI;
        end
      end
      ST_OPCQ: begin
        if (ops_done) begin
          nxt_state = ST_REPLY;
        end
      end
      ST_WAI: begin
        if (ops_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_REPLY: begin
        if (flush || (hs && last)) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= ST_IDLE;
      init_ff <= 1'b1;
      o_cmd_ready <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      init_ff <= 1'b0;
      // Commands keep flowing while only the plain completion command waits.
      o_cmd_ready <= ~init_ff & (nxt_state == ST_IDLE || nxt_state == ST_REPLY);
    end
  end

  // Enable registers, power-on clear setting and their nonvolatile copies.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      psc_ff <= 1'b0;
      ese_ff <= ESE_RESET;
      sre_ff <= SRE_RESET;
      o_nv_wr <= 1'b0;
      o_nv_ese <= ESE_RESET;
      o_nv_sre <= SRE_RESET;
      o_nv_psc <= 1'b0;
    end else begin
      o_nv_wr <= 1'b0;
      if (init_ff) begin
        psc_ff <= i_nv_psc;
        ese_ff <= i_nv_psc ? ESE_RESET : (i_nv_ese & ESE_MASK);
        sre_ff <= i_nv_psc ? SRE_RESET : (i_nv_sre & SRE_MASK);
      end else if (set_cmd) begin
        unique case (i_cmd_code)
          CMD_ESE: begin
            ese_ff <= i_cmd_arg & ESE_MASK;
            o_nv_wr <= ~psc_ff;
            o_nv_ese <= i_cmd_arg & ESE_MASK;
            o_nv_sre <= sre_ff;
            o_nv_psc <= psc_ff;
          end
          CMD_SRE: begin
            sre_ff <= i_cmd_arg & SRE_MASK;
            o_nv_wr <= ~psc_ff;
            o_nv_ese <= ese_ff;
            o_nv_sre <= i_cmd_arg & SRE_MASK;
            o_nv_psc <= psc_ff;
          end
          CMD_PSC: begin
            psc_ff <= i_cmd_arg != 8'h00;
            o_nv_wr <= 1'b1;
            o_nv_ese <= ese_ff;
            o_nv_sre <= sre_ff;
            o_nv_psc <= i_cmd_arg != 8'h00;
          end
          CMD_RST: ese_ff <= ESE_RESET;
          default: ese_ff <= ese_ff;
        endcase
      end
    end
  end

  // Event register: a new event wins over a clear in the same cycle.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      esr_ff <= ESR_RESET;
      opc_pend_ff <= 1'b0;
    end else begin
      esr_ff <= ((do_cls || esr_read) ? 8'h00 : esr_ff) | (esr_set & ESE_MASK);
      if (set_cmd && i_cmd_code == CMD_OPC) begin
        opc_pend_ff <= 1'b1;
      end else if (opc_fire) begin
        opc_pend_ff <= 1'b0;
      end
    end
  end

  // Clearing pulses, status byte and forwarded commands.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_clear_events <= 1'b0;
      o_clear_errq <= 1'b0;
      o_status_byte <= STB_RESET;
      o_fwd_valid <= 1'b0;
      o_fwd_code <= CMD_RST;
      o_fwd_arg <= 8'h00;
    end else begin
      o_clear_events <= do_cls;
      o_clear_errq <= do_cls;
      o_status_byte <= stb_now;
      o_fwd_valid <= set_cmd & (i_cmd_code == CMD_RST || i_cmd_code == CMD_TRG ||
                     ((i_cmd_code == CMD_RCL || i_cmd_code == CMD_SAV) &&
                      i_cmd_arg <= SLOT_MAX));
      if (set_cmd) begin
        o_fwd_code <= i_cmd_code;
        o_fwd_arg <= i_cmd_arg;
      end
    end
  end

  // Output queue: one reply at a time, one character per accepted beat.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 8'h00;
      rsp_idn_ff <= 1'b0;
      rsp_idx_ff <= 6'h00;
      rsp_len_ff <= 6'h00;
      rsp_num_ff <= 24'h000000;
    end else if (flush) begin
      o_rsp_valid <= 1'b0;
    end else if (load) begin
      o_rsp_valid <= 1'b1;
      o_rsp_data <= rsp_char(load_idn, 6'h00, new_len, new_num);
      rsp_idn_ff <= load_idn;
      rsp_idx_ff <= 6'h01;
      rsp_len_ff <= new_len;
      rsp_num_ff <= new_num;
    end else if (hs) begin
      o_rsp_valid <= ~last;
      o_rsp_data <= rsp_char(rsp_idn_ff, rsp_idx_ff, rsp_len_ff, rsp_num_ff);
      rsp_idx_ff <= rsp_idx_ff + 6'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_cls_quiet;
    do_cls && esr_set == 8'h00;
  endsequence
  sequence s_flush_then_idle;
    ##1 !o_rsp_valid ##1 !o_status_byte[STB_MAV];
  endsequence

  property p_cls_clears;
    s_cls_quiet |=> esr_ff == 8'h00 && o_clear_events && ese_ff == $past(ese_ff);
  endproperty
  a_cls_clears: assert property (p_cls_clears) else $error("clear left events set");
  property p_cls_errq;
    do_cls |=> o_clear_errq;
  endproperty
  a_cls_errq: assert property (p_cls_errq) else $error("error queue not cleared");
  property p_cls_opc;
    do_cls && opc_pend_ff |=> esr_ff[ESR_OPC] && !opc_pend_ff;
  endproperty
  a_cls_opc: assert property (p_cls_opc) else $error("pending completion not forced");
  property p_flush;
    flush |-> s_flush_then_idle;
  endproperty
  a_flush: assert property (p_flush) else $error("output queue not flushed");
  property p_ese_write;
    set_cmd && i_cmd_code == CMD_ESE && !init_ff |=> ese_ff == ($past(i_cmd_arg) & ESE_MASK);
  endproperty
  a_ese_write: assert property (p_ese_write) else $error("enable write wrong");
  property p_esb;
    o_status_byte[STB_ESB] == $past(|(esr_ff & ese_ff));
  endproperty
  a_esb: assert property (p_esb) else $error("event summary wrong");
  property p_layout;
    ese_ff[6] == 1'b0 && ese_ff[1] == 1'b0 && esr_ff[6] == 1'b0 && esr_ff[1] == 1'b0;
  endproperty
  a_layout: assert property (p_layout) else $error("unused bit set");
  property p_nv;
    set_cmd && i_cmd_code == CMD_ESE && !psc_ff |=> o_nv_wr && o_nv_ese == ese_ff;
  endproperty
  a_nv: assert property (p_nv) else $error("enable not stored");
  property p_esr_read;
    esr_read && esr_set == 8'h00 |=> esr_ff == 8'h00 ##1 o_rsp_valid;
  endproperty
  a_esr_read: assert property (p_esr_read) else $error("event read did not clear");
  property p_opc_done;
    opc_pend_ff && ops_done |=> esr_ff[ESR_OPC];
  endproperty
  a_opc_done: assert property (p_opc_done) else $error("completion bit not set");
  property p_opc_accept;
    state_ff == ST_IDLE && opc_pend_ff && !init_ff |-> o_cmd_ready;
  endproperty
  a_opc_accept: assert property (p_opc_accept) else $error("commands stalled");
  property p_opcq_reply;
    state_ff == ST_OPCQ && ops_done |=> o_rsp_valid && o_rsp_data == CHAR_ONE;
  endproperty
  a_opcq_reply: assert property (p_opcq_reply) else $error("completion reply missing");
  property p_opcq_hold;
    state_ff == ST_OPCQ |-> !o_cmd_ready;
  endproperty
  a_opcq_hold: assert property (p_opcq_hold) else $error("commands taken too early");
  property p_bad_form;
    bad |=> esr_ff[ESR_CME];
  endproperty
  a_bad_form: assert property (p_bad_form) else $error("wrong form not flagged");
  property p_psc_init;
    init_ff && i_nv_psc |=> ese_ff == 8'h00 && sre_ff == 8'h00;
  endproperty
  a_psc_init: assert property (p_psc_init) else $error("enables not cleared at power-up");
  property p_mav;
    o_status_byte[STB_MAV] == $past(o_rsp_valid);
  endproperty
  a_mav: assert property (p_mav) else $error("message available wrong");

endmodule
`default_nettype wire

// [logic/ccsu_pkg.sv]
// Constants, command codes and states for the common command status unit.
`default_nettype none
package ccsu_pkg;
  // Standard event bit positions, shared by the event and enable registers.
  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;
  localparam logic [7:0] ESE_MASK = 8'hBD;
  localparam logic [7:0] SRE_MASK = 8'hBF;
  // Status byte bit positions.
  localparam int STB_OPER = 7;
  localparam int STB_MSS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QUES = 3;
  // Values after reset.
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] STB_RESET = 8'h00;
  // Highest stored-setting slot.
  localparam logic [7:0] SLOT_MAX = 8'h04;
  // Reply characters.
  localparam logic [7:0] CHAR_NL = 8'h0A;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ONE = 8'h31;
  // Identification reply; every field value is arbitrary.
  localparam int IDN_LEN = 31;
  localparam logic [8*IDN_LEN-1:0] IDN_STR = "XYZCO,1000A,0,f1.00,s1.00,p1.00";
  localparam logic [5:0] IDN_REPLY_LEN = 6'h20;

  typedef enum logic [4:0] {
    CMD_CLS = 5'h00,
    CMD_ESE = 5'h01,
    CMD_ESR = 5'h02,
    CMD_IDN = 5'h03,
    CMD_OPC = 5'h04,
    CMD_RST = 5'h05,
    CMD_SRE = 5'h06,
    CMD_STB = 5'h07,
    CMD_TST = 5'h08,
    CMD_WAI = 5'h09,
    CMD_PSC = 5'h0A,
    CMD_RCL = 5'h0B,
    CMD_SAV = 5'h0C,
    CMD_TRG = 5'h0D
  } cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPCQ = 4'b0010,
    ST_WAI = 4'b0100,
    ST_REPLY = 4'b1000
  } state_t;
endpackage
`default_nettype wire

// [dv/bus_controller_model.sv]
// Controller side model that reads reply characters from the output queue.
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Output queue of the device
  input wire logic i_rsp_valid,
  input wire logic [7:0] i_rsp_data,
  input wire logic i_hold,
  output logic o_rsp_ready
);
  logic [7:0] rx_q[$];

  // Reads the bus with random stalls, and holds ready low while i_hold is set.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp_ready <= 1'b0;
    end else begin
      if (i_rsp_valid && o_rsp_ready) begin
        rx_q.push_back(i_rsp_data);
      end
      o_rsp_ready <= i_hold ? 1'b0 : 1'($urandom_range(0, 1));
    end
  end
endmodule
`default_nettype wire

// [dv/tb_common_command_status_unit.sv]
// Self-checking bench for the common command status unit.
`timescale 1ns/1ps
`default_nettype none
module tb_common_command_status_unit;
  import ccsu_pkg::*;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_cmd_valid = 1'b0, i_cmd_query = 1'b0;
  cmd_t i_cmd_code = CMD_CLS;
  logic [7:0] i_cmd_arg = 8'h00, i_nv_ese = 8'h24, i_nv_sre = 8'h00;
  logic i_cmd_after_term = 1'b0, i_evt_cmd_err = 1'b0, i_evt_exe_err = 1'b0;
  logic i_evt_dev_err = 1'b0, i_evt_qry_err = 1'b0, i_prev_done = 1'b1;
  logic i_level_settled = 1'b1, i_trig_pending = 1'b0, i_oper_summary = 1'b0;
  logic i_ques_summary = 1'b0, i_nv_psc = 1'b0, hold = 1'b0;
  logic o_cmd_ready, o_rsp_valid, i_rsp_ready, o_clear_events, o_clear_errq, o_nv_wr;
  logic o_fwd_valid, o_nv_psc;
  logic [7:0] o_rsp_data, o_status_byte, o_nv_ese, o_nv_sre, o_fwd_arg;
  cmd_t o_fwd_code;
  int error_cnt = 0, total_checks = 0, model_esr = 128, model_ese = 36;
  logic [7:0] a;
  string r;
  cmd_t fwd[4] = '{CMD_RST, CMD_TRG, CMD_RCL, CMD_SAV};

  common_command_status_unit dut (.i_clk, .i_rstn, .i_cmd_valid, .i_cmd_code, .i_cmd_query,
    .i_cmd_arg, .i_cmd_after_term, .o_cmd_ready, .o_rsp_valid, .o_rsp_data, .i_rsp_ready,
    .i_evt_cmd_err, .i_evt_exe_err, .i_evt_dev_err, .i_evt_qry_err, .i_prev_done,
    .i_level_settled, .i_trig_pending, .i_oper_summary, .i_ques_summary, .o_status_byte,
    .o_clear_events, .o_clear_errq, .i_nv_psc, .i_nv_ese, .i_nv_sre, .o_nv_wr, .o_nv_ese,
    .o_nv_sre, .o_nv_psc, .o_fwd_valid, .o_fwd_code, .o_fwd_arg);
  bus_controller_model ctl (.i_clk, .i_rstn, .i_rsp_valid(o_rsp_valid),
    .i_rsp_data(o_rsp_data), .i_hold(hold), .o_rsp_ready(i_rsp_ready));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_str(input string got, input string exp);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until ready is seen, then releases it on the taking edge.
  task automatic send(input cmd_t c, input logic q, input logic [7:0] v, input logic t);
    int n;
    n = 0;
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_code <= c;
    i_cmd_query <= q;
    i_cmd_arg <= v;
    i_cmd_after_term <= t;
    @(negedge i_clk);
    while (o_cmd_ready !== 1'b1 && n < 500) begin
      @(negedge i_clk);
      n++;
    end
    cmp8(8'(n < 500), 8'h01);
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
  endtask

  task automatic get_reply(output string s);
    int n;
    n = 0;
    s = "";
    while ((ctl.rx_q.size() == 0 || ctl.rx_q[$] !== CHAR_NL) && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    foreach (ctl.rx_q[i]) s = {s, string'(ctl.rx_q[i])};
    ctl.rx_q.delete();
  endtask

  task automatic ask(input cmd_t c, input string exp);
    string s;
    send(c, 1'b1, 8'h00, 1'b0);
    get_reply(s);
    cmp_str(s, exp);
  endtask

  task automatic rd_esr();
    ask(CMD_ESR, $sformatf("%0d\n", model_esr));
    model_esr = 0;
  endtask

  task automatic evt(input logic [3:0] m);
    @(posedge i_clk);
    {i_evt_cmd_err, i_evt_exe_err, i_evt_dev_err, i_evt_qry_err} <= m;
    @(posedge i_clk);
    {i_evt_cmd_err, i_evt_exe_err, i_evt_dev_err, i_evt_qry_err} <= 4'h0;
    model_esr = model_esr | (int'(m) << 2);
  endtask

  initial begin
    repeat (50000) @(posedge i_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    void'($urandom(5868));
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    ask(CMD_ESE, "36\n");
    rd_esr();
    rd_esr();
    evt(4'hF);
    rd_esr();
    evt(4'h8);
    repeat (2) @(negedge i_clk);
    cmp8(o_status_byte, 8'h20);
    send(CMD_CLS, 1'b0, 8'h00, 1'b0);
    @(negedge i_clk);
    cmp8({6'h00, o_clear_events, o_clear_errq}, 8'h03);
    model_esr = 0;
    @(negedge i_clk);
    cmp8(o_status_byte, 8'h00);
    ask(CMD_ESE, "36\n");
    rd_esr();
    repeat (4) begin
      a = 8'($urandom);
      send(CMD_ESE, 1'b0, a, 1'b0);
      @(negedge i_clk);
      cmp8({7'h00, o_nv_wr}, 8'h01);
      model_ese = int'(a & 8'hBD);
      cmp8(o_nv_ese, 8'(model_ese));
      ask(CMD_ESE, $sformatf("%0d\n", model_ese));
    end
    @(posedge i_clk);
    i_prev_done <= 1'b0;
    send(CMD_OPC, 1'b0, 8'h00, 1'b0);
    send(CMD_ESE, 1'b0, 8'h01, 1'b0);
    rd_esr();
    @(posedge i_clk);
    i_prev_done <= 1'b1;
    i_trig_pending <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd_esr();
    @(posedge i_clk);
    i_trig_pending <= 1'b0;
    repeat (4) @(posedge i_clk);
    model_esr = 1;
    rd_esr();
    @(posedge i_clk);
    i_level_settled <= 1'b0;
    send(CMD_OPC, 1'b0, 8'h00, 1'b0);
    send(CMD_CLS, 1'b0, 8'h00, 1'b0);
    model_esr = 1;
    rd_esr();
    @(posedge i_clk);
    i_level_settled <= 1'b1;
    i_trig_pending <= 1'b1;
    send(CMD_OPC, 1'b1, 8'h00, 1'b0);
    repeat (3) @(negedge i_clk);
    cmp8({7'h00, o_cmd_ready}, 8'h00);
    cmp8({7'h00, o_rsp_valid}, 8'h00);
    @(posedge i_clk);
    i_trig_pending <= 1'b0;
    get_reply(r);
    cmp_str(r, "1\n");
    ask(CMD_IDN, $sformatf("%s\n", IDN_STR));
    ask(CMD_TST, "0\n");
    send(CMD_ESR, 1'b0, 8'h00, 1'b0);
    model_esr = 32;
    rd_esr();
    foreach (fwd[i]) begin
      send(fwd[i], 1'b0, 8'h04, 1'b0);
      @(negedge i_clk);
      cmp8({o_fwd_valid, 2'h0, o_fwd_code}, {1'b1, 2'h0, fwd[i]});
      cmp8(o_fwd_arg, 8'h04);
    end
    @(posedge i_clk);
    hold <= 1'b1;
    send(CMD_IDN, 1'b1, 8'h00, 1'b0);
    repeat (3) @(negedge i_clk);
    cmp8(o_status_byte & 8'h10, 8'h10);
    send(CMD_CLS, 1'b0, 8'h00, 1'b1);
    repeat (2) @(negedge i_clk);
    cmp8({o_rsp_valid, o_status_byte[4]}, 8'h00);
    @(posedge i_clk);
    hold <= 1'b0;
    ctl.rx_q.delete();
    ask(CMD_TST, "0\n");
    send(CMD_ESE, 1'b0, 8'h10, 1'b0);
    send(CMD_SRE, 1'b0, 8'h20, 1'b0);
    @(negedge i_clk);
    cmp8(o_nv_sre, 8'h20);
    cmp8(o_nv_ese, 8'h10);
    send(CMD_RCL, 1'b0, 8'h05, 1'b0);
    @(negedge i_clk);
    cmp8({7'h00, o_fwd_valid}, 8'h00);
    model_esr = 16;
    @(posedge i_clk);
    hold <= 1'b1;
    i_ques_summary <= 1'b1;
    send(CMD_STB, 1'b1, 8'h00, 1'b0);
    send(CMD_ESE, 1'b1, 8'h00, 1'b0);
    model_esr = 20;
    @(posedge i_clk);
    hold <= 1'b0;
    i_ques_summary <= 1'b0;
    get_reply(r);
    cmp_str(r, "104\n");
    rd_esr();
    send(CMD_PSC, 1'b0, 8'h01, 1'b0);
    @(negedge i_clk);
    cmp8({o_nv_wr, o_nv_psc, 6'h00}, 8'hC0);
    send(CMD_ESE, 1'b0, 8'h81, 1'b0);
    @(negedge i_clk);
    cmp8({7'h00, o_nv_wr}, 8'h00);
    ask(CMD_PSC, "1\n");
    @(posedge i_clk);
    {i_nv_psc, i_nv_ese, i_nv_sre} <= {1'b1, 8'hFF, 8'hFF};
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    model_esr = 128;
    ask(CMD_ESE, "0\n");
    ask(CMD_SRE, "0\n");
    rd_esr();
    @(posedge i_clk);
    i_prev_done <= 1'b0;
    send(CMD_WAI, 1'b0, 8'h00, 1'b0);
    repeat (2) @(negedge i_clk);
    cmp8({7'h00, o_cmd_ready}, 8'h00);
    @(posedge i_clk);
    i_prev_done <= 1'b1;
    ask(CMD_TST, "0\n");
    wrap_up();
  end
endmodule
`default_nettype wire
